// ==== hw/seq_select.v ====
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "seq_select_regs.vh"
module seq_select (
   input  wire        ref_clk,      // 100 MHz clock
   input  wire        rst_n,        // async reset, active low
   input  wire [3:0]  wb_adr_i,     // byte address
   input  wire [31:0] wb_dat_i,     // write data
   output reg  [31:0] wb_dat_o,     // read data
   input  wire        wb_we_i,      // write enable
   input  wire [3:0]  wb_sel_i,     // byte selects
   input  wire        wb_stb_i,     // strobe
   input  wire        wb_cyc_i,     // cycle
   output reg         wb_ack_o,     // acknowledge
   input  wire        line1_in,     // digital input line one
   input  wire        line2_in,     // digital input line two
   input  wire        trig_in,      // frame start trigger
   output reg  [5:0]  set_index,    // set currently used for acquisition
   output reg         set_load,     // pulse: load set_index into active set
   output reg         seq_active,   // high while active set is sequencer-driven
   output reg         wait_trig,    // waiting for frame start trigger
   output reg         frame_start   // pulse: accepted trigger
);

   reg  [1:0]           rst_sync_r;
   wire                 rst_int_n;
   reg  [`CTRL_WIDTH-1:0] ctrl_r;
   reg  [6:0]           count_r;
   reg  [1:0]           l1_sync_r;
   reg  [1:0]           l2_sync_r;
   reg  [1:0]           tr_sync_r;
   reg                  l1_prev_r;
   reg                  l2_prev_r;
   reg                  tr_prev_r;
   reg  [`SETTLE_W-1:0] settle_r;
   reg                  en_prev_r;
   wire                 en;
   wire [1:0]           src;
   wire [1:0]           rsrc;
   wire                 lvl1;
   wire                 lvl2;
   wire                 ctl_lvl;
   wire                 rst_lvl;
   wire                 monitored_change;
   wire                 trig_edge;
   wire                 accept;
   wire                 do_restart;
   wire                 do_advance;
   wire                 wb_req;
   wire [6:0]           count_wr;

   // next index with wrap at count minus one
   function [5:0] next_idx;
      input [5:0] cur;
      input [6:0] cnt;
      begin
         if ({1'b0, cur} + 7'h01 >= cnt)
            next_idx = `INDEX_ZERO;
         else
            next_idx = cur + 6'h01;
      end
   endfunction

   // pick a line level by source code
   function line_pick;
      input [1:0] code;
      input       a;
      input       b;
      begin
         if (code == `SRC_LINE1)
            line_pick = a;
         else if (code == `SRC_LINE2)
            line_pick = b;
         else
            line_pick = 1'b0;
      end
   endfunction

   // reset release through two flip-flops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_int_n = rst_sync_r[1];

   // pin synchronisers and edge history
   always @(posedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         l1_sync_r <= 2'h0;
         l2_sync_r <= 2'h0;
         tr_sync_r <= 2'h0;
         l1_prev_r <= 1'b0;
         l2_prev_r <= 1'b0;
         tr_prev_r <= 1'b0;
      end else begin
         l1_sync_r <= {l1_sync_r[0], line1_in};
         l2_sync_r <= {l2_sync_r[0], line2_in};
         tr_sync_r <= {tr_sync_r[0], trig_in};
         l1_prev_r <= l1_sync_r[1];
         l2_prev_r <= l2_sync_r[1];
         tr_prev_r <= tr_sync_r[1];
      end
   end

   assign en   = ctrl_r[`CTRL_EN_BIT];
   assign src  = ctrl_r[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
   assign rsrc = ctrl_r[`CTRL_RST_MSB:`CTRL_RST_LSB];
   // sensed levels after optional inversion
   assign lvl1 = l1_sync_r[1] ^ ctrl_r[`CTRL_INV1_BIT];
   assign lvl2 = l2_sync_r[1] ^ ctrl_r[`CTRL_INV2_BIT];
   assign ctl_lvl = line_pick(src, lvl1, lvl2);
   assign rst_lvl = line_pick(rsrc, lvl1, lvl2);

   // a change on any line used as control or restart source
   assign monitored_change =
      (((src == `SRC_LINE1) || (rsrc == `RST_LINE1)) && (l1_sync_r[1] != l1_prev_r)) ||
      (((src == `SRC_LINE2) || (rsrc == `RST_LINE2)) && (l2_sync_r[1] != l2_prev_r));

   assign trig_edge  = tr_sync_r[1] && !tr_prev_r;
   assign accept     = trig_edge && (settle_r == {`SETTLE_W{1'b0}}) && !monitored_change;
   assign do_restart = (rsrc != `RST_NONE) && rst_lvl;
   assign do_advance = (src == `SRC_ALWAYS) || (((src == `SRC_LINE1) || (src == `SRC_LINE2)) && ctl_lvl);

   // busy window after a monitored line changes; triggers inside it are dropped
   always @(posedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n)
         settle_r <= {`SETTLE_W{1'b0}};
      else if (monitored_change)
         settle_r <= `SETTLE_CYC;
      else if (settle_r != {`SETTLE_W{1'b0}})
         settle_r <= settle_r - {{(`SETTLE_W-1){1'b0}}, 1'b1};
   end

   // set selection
   always @(posedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         en_prev_r   <= 1'b0;
         set_index   <= `INDEX_ZERO;
         set_load    <= 1'b0;
         seq_active  <= 1'b0;
         frame_start <= 1'b0;
         wait_trig   <= 1'b0;
      end else begin
         en_prev_r   <= en;
         set_load    <= 1'b0;
         frame_start <= accept;
         wait_trig   <= (settle_r == {`SETTLE_W{1'b0}}) && !monitored_change;
         if (!en) begin
            seq_active <= 1'b0;
            set_index  <= `INDEX_ZERO;
         end else if (!en_prev_r) begin
            seq_active <= 1'b1;
            set_index  <= `INDEX_ZERO;
            set_load   <= 1'b1;
         end else if (accept) begin
            if (do_restart) begin
               set_index <= `INDEX_ZERO;
               set_load  <= 1'b1;
            end else if (do_advance) begin
               set_index <= next_idx(set_index, count_r);
               set_load  <= 1'b1;
            end
            // control line low: keep current set, no load
         end
      end
   end

   // clamp written count into 1..64
   assign count_wr = (wb_dat_i[6:0] > `COUNT_MAX || wb_dat_i[31:7] != 25'h0) ? `COUNT_MAX :
                     (wb_dat_i[6:0] < `COUNT_MIN) ? `COUNT_MIN : wb_dat_i[6:0];
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // wishbone slave, one wait state
   always @(posedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_r   <= `CTRL_RESET;
         count_r  <= `COUNT_RESET;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req) begin
            if (wb_adr_i == `SEQ_CTRL_ADDR) begin
               wb_dat_o <= {25'h0, ctrl_r};
               if (wb_we_i && wb_sel_i[0])
                  ctrl_r <= wb_dat_i[`CTRL_WIDTH-1:0];
            end else if (wb_adr_i == `SEQ_COUNT_ADDR) begin
               wb_dat_o <= {25'h0, count_r};
               if (wb_we_i && wb_sel_i[0] && !en)
                  count_r <= count_wr;
            end else if (wb_adr_i == `SEQ_STATUS_ADDR) begin
               wb_dat_o <= {23'h0, wait_trig, seq_active, 1'b0, set_index};
            end
         end
      end
   end

endmodule // seq_select

// ==== hw/seq_select_regs.vh ====
// Summary of operation
// - enabling the sequencer starts a cycle by loading set 0 into the active set
// - free-running source steps to next set on every trigger; with count above 1 the first image uses set 1
// - either input line one or line two may be chosen as the restart source
// - restart line high at a trigger begins a new cycle, using set 0
// - synchronous restart wins over the free-running advance at the same trigger
// - indices run 0 to count minus one; passing the last wraps to 0
// - with a line as control source, its level is sampled at each trigger
// - sampled control line low keeps the current set for that acquisition
// - sampled control line high loads the next set for that acquisition
// - line-gated advance behaves the same for line one and line two
// - while a monitored line changes, leave waiting state and drop triggers
// - disabling stops cycling and the active set reverts to pre-enable values
// - the set count per cycle is limited to at most 64
`ifndef SEQ_SELECT_REGS_VH
`define SEQ_SELECT_REGS_VH
// register byte offsets
`define SEQ_CTRL_ADDR      4'h0
`define SEQ_COUNT_ADDR     4'h4
`define SEQ_STATUS_ADDR    4'h8
// control register fields
`define CTRL_EN_BIT        0
`define CTRL_SRC_LSB       1
`define CTRL_SRC_MSB       2
`define CTRL_RST_LSB       3
`define CTRL_RST_MSB       4
`define CTRL_INV1_BIT      5
`define CTRL_INV2_BIT      6
`define CTRL_WIDTH         7
// control source codes
`define SRC_ALWAYS         2'h0
`define SRC_LINE1          2'h1
`define SRC_LINE2          2'h2
`define SRC_OFF            2'h3
// restart source codes
`define RST_NONE           2'h0
`define RST_LINE1          2'h1
`define RST_LINE2          2'h2
// set count limits and reset values
`define COUNT_MAX          7'h40
`define COUNT_MIN          7'h01
`define COUNT_RESET        7'h01
`define CTRL_RESET         7'h00
`define INDEX_ZERO         6'h00
// line settle window in ns, converted at 100 MHz
// 1000 ns at a 10 ns clock is 100 cycles, sized to the counter width
`define SETTLE_CYC         7'h64
`define SETTLE_W           7
`endif

// ==== bench/seq_select_asserts.sv ====
`timescale 1ns/1ps
module seq_select_asserts (
   input wire        ref_clk,     // clock
   input wire        rst_n,       // reset, active low
   input wire        wb_cyc_i,    // bus cycle
   input wire        wb_stb_i,    // bus strobe
   input wire        wb_ack_o,    // bus acknowledge
   input wire [31:0] wb_dat_o,    // read data
   input wire        trig_in,     // trigger pin
   input wire [5:0]  set_index,   // set in use
   input wire        set_load,    // load pulse
   input wire        seq_active,  // sequencer drives set
   input wire        wait_trig,   // waiting for trigger
   input wire        frame_start  // accepted trigger
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // bus answer timing
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not idle");
   // set selection
   a_enable_zero: assert property ($rose(seq_active) |-> ##[0:1] (set_load && set_index == 6'h00))
      else $error("enable did not load set zero");
   a_load_step: assert property (set_load |-> set_index == 6'h00 || set_index == $past(set_index) + 6'h01)
      else $error("load not next or zero");
   a_hold_index: assert property (seq_active && !set_load |-> $stable(set_index))
      else $error("index moved without load");
   a_start_edge: assert property (frame_start |-> $past(trig_in, 3))
      else $error("start without trigger");
   a_start_waiting: assert property (frame_start |-> $past(wait_trig, 2) || $past(wait_trig, 3))
      else $error("start while not waiting");
   a_start_pulse: assert property (frame_start |=> !frame_start)
      else $error("start too long");
endmodule // seq_select_asserts
bind seq_select seq_select_asserts i_seq_select_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .trig_in(trig_in),
   .set_index(set_index), .set_load(set_load), .seq_active(seq_active), .wait_trig(wait_trig),
   .frame_start(frame_start));

// ==== bench/seq_partner.sv ====
`timescale 1ns/1ps
module seq_partner (
   input  wire ref_clk,    // camera clock
   input  wire wait_trig,  // device waiting
   output reg  line1,      // input line one
   output reg  line2,      // input line two
   output reg  trig        // frame start trigger
);
   // idle levels
   initial begin
      {line1, line2, trig} = 3'b000;
   end
   // set lines, settle, wait, trigger, hold; rude cuts settle to 3 cycles and skips wait
   task frame(input logic a, input logic b, input logic rude);
      integer n;
      begin
         @(posedge ref_clk) {line1, line2} <= {a, b};
         repeat (rude ? 3 : 110) @(posedge ref_clk);
         n = 0;
         while (!rude && wait_trig !== 1'b1 && n < 500) begin
            @(posedge ref_clk);
            n = n + 1;
         end
         trig <= 1'b1;
         repeat (110) @(posedge ref_clk);
         trig <= 1'b0;
         repeat (5) @(posedge ref_clk);
      end
   endtask
endmodule // seq_partner

// ==== bench/test_seq_select.sv ====
`timescale 1ns/1ps
module test_seq_select;
   logic        ref_clk, rst_n, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic        line1_in, line2_in, trig_in, set_load, seq_active, wait_trig, frame_start;
   logic [5:0]  set_index;
   integer      fail_count = 0;
   integer      cmp_count = 0;
   seq_select i_seq_select (.ref_clk(ref_clk), .rst_n(rst_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
      .wb_ack_o(wb_ack_o), .line1_in(line1_in), .line2_in(line2_in), .trig_in(trig_in),
      .set_index(set_index), .set_load(set_load), .seq_active(seq_active), .wait_trig(wait_trig),
      .frame_start(frame_start));
   seq_partner i_seq_partner (.ref_clk(ref_clk), .wait_trig(wait_trig), .line1(line1_in),
      .line2(line2_in), .trig(trig_in));
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, waits for ack
   task wb(input logic [3:0] a, input logic we, input logic [31:0] d);
      integer n;
      begin
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
         n = 0;
         @(posedge ref_clk);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n = n + 1;
         end
         if (n >= 20) begin
            fail_count = fail_count + 1;
            $display("[ERR] t=%0t bus ack timeout adr=%h", $time, a);
         end
         rd = wb_dat_o;
         {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
         @(posedge ref_clk);
      end
   endtask
   task en(input logic [31:0] c);
      wb(4'h0, 1'b1, 32'h0);
      wb(4'h0, 1'b1, c);
      wb(4'h8, 1'b0, 32'h0);
      chk(rd & 32'hbf, 32'h80);
   endtask
   task fr(input logic a, input logic b, input logic [5:0] e);
      i_seq_partner.frame(a, b, 1'b0);
      chk({26'h0, set_index}, {26'h0, e});
   endtask
   task t_regs;
      wb(4'h4, 1'b0, 32'h0);
      chk(rd, 32'h1);
      wb(4'h4, 1'b1, 32'h50);
      wb(4'h4, 1'b0, 32'h0);
      chk(rd, 32'h40);
      wb(4'hc, 1'b0, 32'h0);
      chk(rd, 32'h0);
      wb(4'h4, 1'b1, 32'h6);
      $display("regs done");
   endtask
   task t_free;
      for (int i = 1; i < 8; i++) begin
         if (i == 1) en(32'h1);
         fr(1'b0, 1'b0, 6'(i % 6));
      end
      $display("free-run done");
   endtask
   task t_restart;
      en(32'h9);
      fr(1'b0, 1'b0, 6'h1);
      fr(1'b1, 1'b0, 6'h0);
      fr(1'b0, 1'b0, 6'h1);
      en(32'h11);
      fr(1'b0, 1'b0, 6'h1);
      fr(1'b0, 1'b1, 6'h0);
      i_seq_partner.frame(1'b0, 1'b0, 1'b1);
      chk({26'h0, set_index}, 32'h0);
      fr(1'b0, 1'b0, 6'h1);
      $display("restart done");
   endtask
   task t_gated;
      en(32'h23);
      fr(1'b1, 1'b0, 6'h0);
      fr(1'b0, 1'b0, 6'h1);
      fr(1'b1, 1'b0, 6'h1);
      en(32'h5);
      fr(1'b1, 1'b0, 6'h0);
      fr(1'b1, 1'b1, 6'h1);
      fr(1'b0, 1'b1, 6'h2);
      wb(4'h0, 1'b1, 32'h0);
      wb(4'h8, 1'b0, 32'h0);
      chk(rd & 32'h80, 32'h0);
      $display("gated done");
   endtask
   task finish_test;
      $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #300000;
      fail_count = fail_count + 1;
      finish_test;
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      wb_sel_i = 4'h1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_regs;
      t_free;
      t_restart;
      t_gated;
      finish_test;
   end
endmodule // test_seq_select
